// ===== bench/interrupter_model.sv
`timescale 1ns/1ps
module interrupter_model
(
   // clock
   input  wire logic        clock_in,
   // timer requests
   input  wire logic        irq_one_in,
   input  wire logic        irq_two_in,
   input  wire logic [7:0]  vector_one_in,
   input  wire logic [7:0]  vector_two_in,
   // resets seen
   input  wire logic        system_reset_in,
   input  wire logic        local_reset_in,
   // what was seen
   output logic      [15:0] irqs_one_out,
   output logic      [15:0] irqs_two_out,
   output logic      [7:0]  last_one_out,
   output logic      [7:0]  last_two_out,
   output logic      [15:0] sys_cycles_out,
   output logic      [15:0] local_cycles_out
);
   initial
   begin
      irqs_one_out = 16'h0000;
      irqs_two_out = 16'h0000;
      last_one_out = 8'h00;
      last_two_out = 8'h00;
      sys_cycles_out = 16'h0000;
      local_cycles_out = 16'h0000;
   end
   // accept each request at once, keep its vector
   always @(posedge clock_in)
   begin
      if (irq_one_in === 1'b1)
      begin
         irqs_one_out <= irqs_one_out + 16'h0001;
         last_one_out <= vector_one_in;
      end
      if (irq_two_in === 1'b1)
      begin
         irqs_two_out <= irqs_two_out + 16'h0001;
         last_two_out <= vector_two_in;
      end
      sys_cycles_out <= sys_cycles_out + {15'h0000, system_reset_in === 1'b1};
      local_cycles_out <= local_cycles_out + {15'h0000, local_reset_in === 1'b1};
   end
endmodule // interrupter_model

// ===== bench/watchdog_tick_timer_prescaler_bench.sv
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         num_errors++; \
         $display("[ERR] %s expected %h seen %h", what, exp, got); \
      end \
   end
module watchdog_tick_timer_prescaler_bench;
   logic        clock_in = 1'b0;
   logic        reset_in = 1'b1;
   logic [7:0]  aw_addr = 8'h00;
   logic        aw_valid = 1'b0;
   logic        aw_ready;
   logic [31:0] w_data = 32'h0000_0000;
   logic [3:0]  w_strb = 4'h0;
   logic        w_valid = 1'b0;
   logic        w_ready;
   logic [1:0]  b_resp;
   logic        b_valid;
   logic        b_ready = 1'b0;
   logic [7:0]  ar_addr = 8'h00;
   logic        ar_valid = 1'b0;
   logic        ar_ready;
   logic [31:0] r_data;
   logic [1:0]  r_resp;
   logic        r_valid;
   logic        r_ready = 1'b0;
   logic        fail_line = 1'b0;
   logic        strap = 1'b0;
   logic        sys_reset, local_reset, board_fail, irq_one, irq_two;
   logic [7:0]  vec_one, vec_two, last_one, last_two;
   logic [15:0] irqs_one, irqs_two, sys_cycles, local_cycles, s, l;
   logic [31:0] rd, keep;
   logic [1:0]  rs;
   int          num_errors = 0;
   int          comparisons = 0;
   int          n;

   always #5 clock_in = ~clock_in;

   timer_block uut (.clock_in(clock_in), .reset_in(reset_in),
      .s_axi_awaddr_in(aw_addr), .s_axi_awvalid_in(aw_valid), .s_axi_awready_out(aw_ready),
      .s_axi_wdata_in(w_data), .s_axi_wstrb_in(w_strb), .s_axi_wvalid_in(w_valid),
      .s_axi_wready_out(w_ready), .s_axi_bresp_out(b_resp), .s_axi_bvalid_out(b_valid),
      .s_axi_bready_in(b_ready), .s_axi_araddr_in(ar_addr), .s_axi_arvalid_in(ar_valid),
      .s_axi_arready_out(ar_ready), .s_axi_rdata_out(r_data), .s_axi_rresp_out(r_resp),
      .s_axi_rvalid_out(r_valid), .s_axi_rready_in(r_ready),
      .backplane_fail_in(fail_line), .system_controller_in(strap),
      .system_reset_out(sys_reset), .local_bus_reset_out(local_reset),
      .board_fail_pin_out(board_fail), .tick_one_irq_out(irq_one),
      .tick_two_irq_out(irq_two), .tick_one_vector_out(vec_one),
      .tick_two_vector_out(vec_two));

   interrupter_model partner (.clock_in(clock_in), .irq_one_in(irq_one),
      .irq_two_in(irq_two), .vector_one_in(vec_one), .vector_two_in(vec_two),
      .system_reset_in(sys_reset), .local_reset_in(local_reset),
      .irqs_one_out(irqs_one), .irqs_two_out(irqs_two), .last_one_out(last_one),
      .last_two_out(last_two), .sys_cycles_out(sys_cycles), .local_cycles_out(local_cycles));

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic expire(input int k, input int lim);
      if (k >= lim)
      begin
         num_errors++;
         $display("[ERR] wait expected done seen expired");
         end_of_test();
      end
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
      int   k;
      logic pa, pw, pb;
      @(posedge clock_in);
      aw_addr <= a;
      w_data <= d;
      w_strb <= st;
      aw_valid <= 1'b1;
      w_valid <= 1'b1;
      b_ready <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      pb = 1'b1;
      for (k = 0; k < 40 && (pa || pw || pb); k++)
      begin
         @(negedge clock_in);
         pa = pa && !aw_ready;
         pw = pw && !w_ready;
         pb = pb && !b_valid;
         @(posedge clock_in);
         aw_valid <= pa;
         w_valid <= pw;
         b_ready <= pb;
      end
      expire(k, 40);
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int   k;
      logic pa, pr;
      @(posedge clock_in);
      ar_addr <= a;
      ar_valid <= 1'b1;
      r_ready <= 1'b1;
      pa = 1'b1;
      pr = 1'b1;
      for (k = 0; k < 40 && (pa || pr); k++)
      begin
         @(negedge clock_in);
         pa = pa && !ar_ready;
         d = r_data;
         r = r_resp;
         pr = pr && !r_valid;
         @(posedge clock_in);
         ar_valid <= pa;
         r_ready <= pr;
      end
      expire(k, 40);
   endtask

   task automatic test_defaults();
      fail_line <= 1'b1;
      repeat (4) @(posedge clock_in);
      axi_read(timer_pkg::control_offset, rd, rs);
      `CHECK("control fail", 32'h2000_0000, rd)
      fail_line <= 1'b0;
      strap <= 1'b1;
      repeat (4) @(posedge clock_in);
      axi_read(timer_pkg::control_offset, rd, rs);
      `CHECK("control strap", 32'h4000_0000, rd)
      axi_read(8'h00, rd, rs);
      `CHECK("unmapped resp", timer_pkg::resp_slverr, rs)
      `CHECK("unmapped data", 32'h0000_0000, rd)
      $display("test defaults done");
   endtask

   task automatic test_prescaler();
      axi_write(timer_pkg::prescaler_offset, 32'h0000_1200, 4'hf);
      axi_read(timer_pkg::prescaler_offset, rd, rs);
      `CHECK("prescaler upper", 24'h000012, rd[31:8])
      `CHECK("prescaler low", 1'b1, rd[7:0] > 8'h00 && rd[7:0] < 8'h10)
      repeat (260) @(posedge clock_in);
      axi_read(timer_pkg::prescaler_offset, rd, rs);
      `CHECK("reload upper", 24'h000013, rd[31:8])
      `CHECK("reload low", 1'b1, rd[7:0] >= timer_pkg::adjust_reset)
      axi_write(timer_pkg::adjust_offset, 32'h0000_00ff, 4'h1);
      `CHECK("refused resp", timer_pkg::resp_okay, b_resp)
      axi_read(timer_pkg::adjust_offset, rd, rs);
      `CHECK("adjust refused", timer_pkg::adjust_reset, rd[7:0])
      axi_write(timer_pkg::adjust_offset, 32'h0000_00fe, 4'h1);
      axi_read(timer_pkg::adjust_offset, rd, rs);
      `CHECK("adjust taken", 8'hfe, rd[7:0])
      $display("test prescaler done");
   endtask

   task automatic test_ticks();
      axi_write(timer_pkg::vector_base_offset, 32'h0000_0005, 4'h1);
      axi_write(timer_pkg::compare_one_offset, 32'h0000_0003, 4'hf);
      axi_write(timer_pkg::counter_one_offset, 32'h0000_0000, 4'hf);
      axi_write(timer_pkg::compare_two_offset, 32'h0000_0002, 4'hf);
      axi_write(timer_pkg::counter_two_offset, 32'h0000_0000, 4'hf);
      axi_write(timer_pkg::control_offset, 32'h0000_0103, 4'h3);
      for (n = 0; n < 200 && irqs_one < 16'h0003; n++)
         @(posedge clock_in);
      expire(n, 200);
      `CHECK("vector one", 8'h58, last_one)
      `CHECK("vector two", 8'h59, last_two)
      `CHECK("irqs two", 16'h0001, irqs_two)
      axi_write(timer_pkg::control_offset, 32'h0000_0000, 4'h3);
      axi_read(timer_pkg::counter_one_offset, keep, rs);
      `CHECK("counter one wrap", 1'b1, keep <= 32'h0000_0003)
      repeat (20) @(posedge clock_in);
      axi_read(timer_pkg::counter_one_offset, rd, rs);
      `CHECK("counter one held", keep, rd)
      axi_read(timer_pkg::counter_two_offset, rd, rs);
      `CHECK("counter two past", 1'b1, rd > 32'h0000_0002)
      axi_read(timer_pkg::control_offset, rd, rs);
      `CHECK("overflow one", irqs_one[3:0], rd[7:4])
      `CHECK("overflow two", irqs_two[3:0], rd[15:12])
      axi_write(timer_pkg::control_offset, 32'h0000_0404, 4'h3);
      axi_read(timer_pkg::control_offset, rd, rs);
      `CHECK("overflow cleared", 16'h0000, rd[15:0])
      $display("test ticks done");
   endtask

   task automatic test_watchdog();
      axi_write(timer_pkg::control_offset, 32'h0008_0000, 4'h4);
      repeat (1500) @(posedge clock_in);
      `CHECK("idle pin", 1'b0, board_fail)
      for (n = 0; n < 3; n++)
      begin
         axi_write(timer_pkg::control_offset, 32'h0029_0000, 4'h4);
         repeat (600) @(posedge clock_in);
      end
      `CHECK("kicked pin", 1'b0, board_fail)
      s = sys_cycles;
      l = local_cycles;
      axi_write(timer_pkg::control_offset, 32'h000b_0000, 4'h4);
      for (n = 0; n < 1200 && board_fail !== 1'b1; n++)
         @(posedge clock_in);
      expire(n, 1200);
      repeat (120) @(posedge clock_in);
      `CHECK("local pulse", 16'(timer_pkg::reset_pulse_cycles), local_cycles - l)
      `CHECK("no system pulse", s, sys_cycles)
      axi_read(timer_pkg::control_offset, rd, rs);
      `CHECK("expiry set", 8'h1b, rd[23:16])
      axi_write(timer_pkg::control_offset, 32'h0048_0000, 4'h4);
      axi_read(timer_pkg::control_offset, rd, rs);
      `CHECK("expiry cleared", 8'h08, rd[23:16])
      `CHECK("pin released", 1'b0, board_fail)
      $display("test watchdog done");
   endtask

   task automatic test_sysreset();
      s = sys_cycles;
      l = local_cycles;
      axi_write(timer_pkg::control_offset, 32'h0080_0000, 4'h4);
      for (n = 0; n < 300 && (sys_reset === 1'b1 || sys_cycles == s); n++)
         @(posedge clock_in);
      expire(n, 300);
      repeat (2) @(posedge clock_in);
      `CHECK("system pulse", 16'(timer_pkg::reset_pulse_cycles), sys_cycles - s)
      `CHECK("local follows", sys_cycles - s, local_cycles - l)
      axi_read(timer_pkg::control_offset, rd, rs);
      `CHECK("request cleared", 8'h00, rd[23:16])
      axi_read(timer_pkg::adjust_offset, rd, rs);
      `CHECK("adjust reinit", timer_pkg::adjust_reset, rd[7:0])
      $display("test sysreset done");
   endtask

   initial
   begin
      repeat (2) @(posedge clock_in);
      reset_in <= 1'b0;
      test_defaults();
      test_prescaler();
      test_ticks();
      test_watchdog();
      test_sysreset();
      end_of_test();
   end
endmodule // watchdog_tick_timer_prescaler_bench

// ===== rtl/tick_timer.sv
`timescale 1ns/1ps
module tick_timer
(
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        reset_in,
   // controls
   input  wire logic        tick_in,
   input  wire logic        run_in,
   input  wire logic        coc_in,
   input  wire logic        ovf_clear_in,
   input  wire logic        load_in,
   input  wire logic [31:0] load_value_in,
   input  wire logic [31:0] compare_in,
   // state
   output logic      [31:0] count_out,
   output logic      [3:0]  overflow_out,
   output logic             match_out
);
   logic        [31:0] count_q;
   logic        [31:0] count_d;
   logic        [3:0]  ovf_q;
   logic        [3:0]  ovf_d;
   logic               match_q;
   wire logic          hit;
   wire logic          step;

   assign hit  = run_in && tick_in && (count_q == compare_in);
   assign step = run_in && tick_in;

   always_comb
   begin
      count_d = count_q;
      if (load_in)
         count_d = load_value_in;
      else if (hit && coc_in)
         count_d = 32'h0000_0000;
      else if (step)
         count_d = count_q + 32'h0000_0001;
      ovf_d = ovf_q;
      if (hit)
         ovf_d = ovf_q + 4'h1;
      if (ovf_clear_in)
         ovf_d = 4'h0;
   end

   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         count_q <= 32'h0000_0000;
         ovf_q   <= 4'h0;
         match_q <= 1'b0;
      end
      else
      begin
         count_q <= count_d;
         ovf_q   <= ovf_d;
         match_q <= hit;
      end
   end

   assign count_out    = count_q;
   assign overflow_out = ovf_q;
   assign match_out    = match_q;

   hold_a: assert property (@(posedge clock_in) disable iff (reset_in)
      (!run_in && !load_in) |=> $stable(count_q))
      else $error("counter moved while stopped");
endmodule // tick_timer

// ===== rtl/timer_block.sv
`timescale 1ns/1ps
module timer_block
(
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        reset_in,
   // axi4-lite write
   input  wire logic [7:0]  s_axi_awaddr_in,
   input  wire logic        s_axi_awvalid_in,
   output logic             s_axi_awready_out,
   input  wire logic [31:0] s_axi_wdata_in,
   input  wire logic [3:0]  s_axi_wstrb_in,
   input  wire logic        s_axi_wvalid_in,
   output logic             s_axi_wready_out,
   output logic [1:0]       s_axi_bresp_out,
   output logic             s_axi_bvalid_out,
   input  wire logic        s_axi_bready_in,
   // axi4-lite read
   input  wire logic [7:0]  s_axi_araddr_in,
   input  wire logic        s_axi_arvalid_in,
   output logic             s_axi_arready_out,
   output logic [31:0]      s_axi_rdata_out,
   output logic [1:0]       s_axi_rresp_out,
   output logic             s_axi_rvalid_out,
   input  wire logic        s_axi_rready_in,
   // board status
   input  wire logic        backplane_fail_in,
   input  wire logic        system_controller_in,
   // resets and fail
   output logic             system_reset_out,
   output logic             local_bus_reset_out,
   output logic             board_fail_pin_out,
   // interrupter requests
   output logic             tick_one_irq_out,
   output logic             tick_two_irq_out,
   output logic [7:0]       tick_one_vector_out,
   output logic [7:0]       tick_two_vector_out
);
   localparam int pulse_cycles = timer_pkg::reset_pulse_cycles;

   logic        [31:0] pre_q;
   logic        [7:0]  adjust_q;
   logic        [3:0]  period_q;
   logic        [3:0]  vbase_q;
   logic        [7:0]  t1_ctl_q;
   logic        [7:0]  t2_ctl_q;
   logic        [31:0] cmp1_q;
   logic        [31:0] cmp2_q;
   logic        [3:0]  wd_ctl_q;
   logic               expiry_q;
   logic        [31:0] wd_count_q;
   logic        [7:0]  pulse_q;
   logic               pulse_sys_q;
   logic               aw_q;
   logic               w_q;
   logic        [7:0]  awaddr_q;
   logic        [31:0] wdata_q;
   logic        [3:0]  wstrb_q;
   logic               bvalid_q;
   logic               rvalid_q;
   logic        [31:0] rdata_q;
   logic        [1:0]  rresp_q;
   logic        [1:0]  bresp_q;
   logic               sysr_q;
   logic               locr_q;
   logic               fail_q;
   logic               irq1_q;
   logic               irq2_q;
   logic        [7:0]  vec1_q;
   logic        [7:0]  vec2_q;

   wire logic          tick;
   wire logic          wr_go;
   wire logic          wr_ctl;
   wire logic [31:0]   ctl_word;
   wire logic [31:0]   rd_word;
   wire logic          rd_hit;
   wire logic          wr_hit;
   wire logic [31:0]   wd_limit;
   wire logic          wd_expire;
   wire logic [31:0]   cnt1;
   wire logic [31:0]   cnt2;
   wire logic [3:0]    ovf1;
   wire logic [3:0]    ovf2;
   wire logic          match1;
   wire logic          match2;
   wire logic          ovf1_clr;
   wire logic          ovf2_clr;
   wire logic          wd_clr;
   wire logic          st_clr;
   wire logic          system_reset_request_req;
   wire logic          wd_reset_fire;

   function automatic logic known(input logic [7:0] a);
      known = (a == timer_pkg::control_offset) || (a == timer_pkg::prescaler_offset)
         || (a == timer_pkg::compare_one_offset) || (a == timer_pkg::counter_one_offset)
         || (a == timer_pkg::compare_two_offset) || (a == timer_pkg::counter_two_offset)
         || (a == timer_pkg::adjust_offset) || (a == timer_pkg::vector_base_offset)
         || (a == timer_pkg::period_offset);
   endfunction

   function automatic logic wr_at(input logic [7:0] a, input logic [7:0] off);
      wr_at = (a == off);
   endfunction

   // write handshake
   assign wr_go   = aw_q && w_q && !bvalid_q;
   assign wr_hit  = known(awaddr_q);
   assign wr_ctl  = wr_go && wr_at(awaddr_q, timer_pkg::control_offset);
   assign ovf1_clr = wr_ctl && wstrb_q[0]
      && wdata_q[timer_pkg::tick_one_pos + timer_pkg::tick_ovf_clear_bit];
   assign ovf2_clr = wr_ctl && wstrb_q[1]
      && wdata_q[timer_pkg::tick_two_pos + timer_pkg::tick_ovf_clear_bit];
   assign wd_clr   = wr_ctl && wstrb_q[2] && wdata_q[timer_pkg::wd_count_clear_bit];
   assign st_clr   = wr_ctl && wstrb_q[2] && wdata_q[timer_pkg::wd_status_clear_bit];
   assign system_reset_request_req = wr_ctl && wstrb_q[2] && wdata_q[timer_pkg::sys_reset_req_bit];

   // prescaler microsecond tick
   assign tick = (pre_q[7:0] == 8'hff);

   // watchdog period: base doubled per code step
   assign wd_limit  = timer_pkg::wd_base_us << period_q;
   assign wd_expire = wd_ctl_q[0] && tick && (wd_count_q >= wd_limit - 32'h0000_0001);
   assign wd_reset_fire = wd_expire && wd_ctl_q[1];

   // control readback, strobes read zero
   assign ctl_word = {1'b0, system_controller_in, backplane_fail_in, 5'h00,
                      3'h0, expiry_q, wd_ctl_q,
                      ovf2, 1'b0, 1'b0, t2_ctl_q[1:0],
                      ovf1, 1'b0, 1'b0, t1_ctl_q[1:0]};

   assign rd_hit  = known(s_axi_araddr_in);
   assign rd_word =
      (s_axi_araddr_in == timer_pkg::control_offset)     ? ctl_word :
      (s_axi_araddr_in == timer_pkg::prescaler_offset)   ? pre_q :
      (s_axi_araddr_in == timer_pkg::compare_one_offset) ? cmp1_q :
      (s_axi_araddr_in == timer_pkg::counter_one_offset) ? cnt1 :
      (s_axi_araddr_in == timer_pkg::compare_two_offset) ? cmp2_q :
      (s_axi_araddr_in == timer_pkg::counter_two_offset) ? cnt2 :
      (s_axi_araddr_in == timer_pkg::adjust_offset)      ? {24'h000000, adjust_q} :
      (s_axi_araddr_in == timer_pkg::vector_base_offset) ? {28'h0000000, vbase_q} :
      (s_axi_araddr_in == timer_pkg::period_offset)      ? {28'h0000000, period_q} :
      32'h0000_0000;

   tick_timer u_one
   (
      .clock_in      (clock_in),
      .reset_in      (reset_in || pulse_sys_q),
      .tick_in       (tick),
      .run_in        (t1_ctl_q[timer_pkg::tick_run_bit]),
      .coc_in        (t1_ctl_q[timer_pkg::tick_coc_bit]),
      .ovf_clear_in  (ovf1_clr),
      .load_in       (wr_go && wr_at(awaddr_q, timer_pkg::counter_one_offset)),
      .load_value_in (wdata_q),
      .compare_in    (cmp1_q),
      .count_out     (cnt1),
      .overflow_out  (ovf1),
      .match_out     (match1)
   );

   tick_timer u_two
   (
      .clock_in      (clock_in),
      .reset_in      (reset_in || pulse_sys_q),
      .tick_in       (tick),
      .run_in        (t2_ctl_q[timer_pkg::tick_run_bit]),
      .coc_in        (t2_ctl_q[timer_pkg::tick_coc_bit]),
      .ovf_clear_in  (ovf2_clr),
      .load_in       (wr_go && wr_at(awaddr_q, timer_pkg::counter_two_offset)),
      .load_value_in (wdata_q),
      .compare_in    (cmp2_q),
      .count_out     (cnt2),
      .overflow_out  (ovf2),
      .match_out     (match2)
   );

   // axi handshake
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q  <= timer_pkg::resp_okay;
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= timer_pkg::resp_okay;
      end
      else
      begin
         if (s_axi_awvalid_in && !aw_q && !bvalid_q)
         begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && !w_q && !bvalid_q)
         begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata_in;
            wstrb_q <= s_axi_wstrb_in;
         end
         if (wr_go)
         begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= wr_hit ? timer_pkg::resp_okay : timer_pkg::resp_slverr;
         end
         else if (bvalid_q && s_axi_bready_in)
            bvalid_q <= 1'b0;
         if (s_axi_arvalid_in && !rvalid_q)
         begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_hit ? timer_pkg::resp_okay : timer_pkg::resp_slverr;
         end
         else if (rvalid_q && s_axi_rready_in)
            rvalid_q <= 1'b0;
      end
   end

   // registers and timers; system reset reinitialises them
   always_ff @(posedge clock_in)
   begin
      if (reset_in || pulse_sys_q)
      begin
         pre_q      <= 32'h0000_0000;
         adjust_q   <= timer_pkg::adjust_reset;
         period_q   <= timer_pkg::period_reset;
         vbase_q    <= 4'h0;
         t1_ctl_q   <= 8'h00;
         t2_ctl_q   <= 8'h00;
         cmp1_q     <= 32'h0000_0000;
         cmp2_q     <= 32'h0000_0000;
         wd_ctl_q   <= 4'h0;
         expiry_q   <= 1'b0;
         wd_count_q <= 32'h0000_0000;
      end
      else
      begin
         if (wr_go && wr_at(awaddr_q, timer_pkg::prescaler_offset))
            pre_q <= wdata_q;
         else if (tick)
            pre_q <= {pre_q[31:8] + 24'h000001, adjust_q};
         else
            pre_q <= pre_q + 32'h0000_0001;
         if (wr_go && wr_at(awaddr_q, timer_pkg::adjust_offset) && wstrb_q[0]
             && wdata_q[7:0] != timer_pkg::adjust_forbidden)
            adjust_q <= wdata_q[7:0];
         if (wr_go && wr_at(awaddr_q, timer_pkg::period_offset) && wstrb_q[0])
            period_q <= wdata_q[3:0];
         if (wr_go && wr_at(awaddr_q, timer_pkg::vector_base_offset) && wstrb_q[0])
            vbase_q <= wdata_q[3:0];
         if (wr_go && wr_at(awaddr_q, timer_pkg::compare_one_offset))
            cmp1_q <= wdata_q;
         if (wr_go && wr_at(awaddr_q, timer_pkg::compare_two_offset))
            cmp2_q <= wdata_q;
         if (wr_ctl && wstrb_q[0])
            t1_ctl_q <= {6'h00, wdata_q[1:0]};
         if (wr_ctl && wstrb_q[1])
            t2_ctl_q <= {6'h00, wdata_q[9:8]};
         if (wr_ctl && wstrb_q[2])
            wd_ctl_q <= wdata_q[19:16];
         if (wd_expire)
            expiry_q <= 1'b1;
         else if (st_clr)
            expiry_q <= 1'b0;
         if (wd_clr || wd_expire)
            wd_count_q <= 32'h0000_0000;
         else if (wd_ctl_q[0] && tick)
            wd_count_q <= wd_count_q + 32'h0000_0001;
      end
   end

   // reset pulse generator
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         pulse_q     <= 8'h00;
         pulse_sys_q <= 1'b0;
      end
      else if (system_reset_request_req || wd_reset_fire)
      begin
         pulse_q     <= 8'(pulse_cycles);
         pulse_sys_q <= system_reset_request_req || wd_ctl_q[2];
      end
      else if (pulse_q != 8'h00)
         pulse_q <= pulse_q - 8'h01;
      else
         pulse_sys_q <= 1'b0;
   end

   // outputs
   always_ff @(posedge clock_in)
   begin
      if (reset_in)
      begin
         sysr_q <= 1'b0;
         locr_q <= 1'b0;
         fail_q <= 1'b0;
         irq1_q <= 1'b0;
         irq2_q <= 1'b0;
         vec1_q <= 8'h00;
         vec2_q <= 8'h00;
      end
      else
      begin
         sysr_q <= (pulse_q != 8'h00) && pulse_sys_q;
         locr_q <= (pulse_q != 8'h00);
         fail_q <= wd_ctl_q[3] && expiry_q;
         irq1_q <= match1;
         irq2_q <= match2;
         vec1_q <= {vbase_q, timer_pkg::vector_one_low};
         vec2_q <= {vbase_q, timer_pkg::vector_two_low};
      end
   end

   assign s_axi_awready_out   = !aw_q && !bvalid_q;
   assign s_axi_wready_out    = !w_q && !bvalid_q;
   assign s_axi_bvalid_out    = bvalid_q;
   assign s_axi_bresp_out     = bresp_q;
   assign s_axi_arready_out   = !rvalid_q;
   assign s_axi_rvalid_out    = rvalid_q;
   assign s_axi_rdata_out     = rdata_q;
   assign s_axi_rresp_out     = rresp_q;
   assign system_reset_out    = sysr_q;
   assign local_bus_reset_out = locr_q;
   assign board_fail_pin_out  = fail_q;
   assign tick_one_irq_out    = irq1_q;
   assign tick_two_irq_out    = irq2_q;
   assign tick_one_vector_out = vec1_q;
   assign tick_two_vector_out = vec2_q;

   sequence expire_s;
      wd_expire && wd_ctl_q[1] && !wd_ctl_q[2] && !system_reset_request_req;
   endsequence

   wd_idle_a: assert property (@(posedge clock_in) disable iff (reset_in || pulse_sys_q)
      !wd_ctl_q[0] && !wd_clr |=> $stable(wd_count_q))
      else $error("watchdog counted while disabled");
   no_reset_a: assert property (@(posedge clock_in) disable iff (reset_in)
      (pulse_q == 8'h00) && !wd_reset_fire && !system_reset_request_req |=> pulse_q == 8'h00)
      else $error("reset without cause");
   local_scope_a: assert property (@(posedge clock_in) disable iff (reset_in)
      expire_s |-> ##2 (local_bus_reset_out && !system_reset_out))
      else $error("local reset scope wrong");
   fail_pin_a: assert property (@(posedge clock_in) disable iff (reset_in)
      board_fail_pin_out |-> $past(wd_ctl_q[3] && expiry_q))
      else $error("board fail without cause");
   expiry_set_a: assert property (@(posedge clock_in) disable iff (reset_in || pulse_sys_q)
      wd_expire |=> expiry_q)
      else $error("expiry not recorded");
   expiry_keep_a: assert property (@(posedge clock_in) disable iff (reset_in || pulse_sys_q)
      expiry_q && !st_clr |=> expiry_q)
      else $error("expiry dropped");
   presc_reload_a: assert property (@(posedge clock_in) disable iff (reset_in || pulse_sys_q)
      tick && !wr_go |=> pre_q[7:0] == $past(adjust_q))
      else $error("prescaler reload wrong");
   adjust_guard_a: assert property (@(posedge clock_in) disable iff (reset_in)
      adjust_q != timer_pkg::adjust_forbidden)
      else $error("adjust holds all ones");
   vector_a: assert property (@(posedge clock_in) disable iff (reset_in)
      !$past(reset_in) |-> tick_two_vector_out == {$past(vbase_q), timer_pkg::vector_two_low})
      else $error("vector low nibble wrong");
endmodule // timer_block

// ===== shared/timer_pkg.sv
package timer_pkg;
   // register byte addresses
   localparam logic [7:0] control_offset      = 8'h60;
   localparam logic [7:0] prescaler_offset    = 8'h64;
   localparam logic [7:0] compare_one_offset  = 8'h50;
   localparam logic [7:0] counter_one_offset  = 8'h54;
   localparam logic [7:0] compare_two_offset  = 8'h58;
   localparam logic [7:0] counter_two_offset  = 8'h5c;
   localparam logic [7:0] adjust_offset       = 8'h4c;
   localparam logic [7:0] vector_base_offset  = 8'h70;
   localparam logic [7:0] period_offset       = 8'h74;
   // control word fields
   localparam int tick_one_pos          = 0;
   localparam int tick_two_pos          = 8;
   localparam int tick_run_bit          = 0;
   localparam int tick_coc_bit          = 1;
   localparam int tick_ovf_clear_bit    = 2;
   localparam int tick_ovf_pos          = 4;
   localparam int wd_run_bit            = 16;
   localparam int wd_reset_enable_bit   = 17;
   localparam int wd_scope_bit          = 18;
   localparam int wd_boardfail_bit      = 19;
   localparam int wd_expiry_bit         = 20;
   localparam int wd_count_clear_bit    = 21;
   localparam int wd_status_clear_bit   = 22;
   localparam int sys_reset_req_bit     = 23;
   localparam int fail_status_bit       = 29;
   localparam int controller_status_bit = 30;
   // reset values and constants
   localparam logic [7:0]  adjust_reset     = 8'hdf;
   localparam logic [7:0]  adjust_forbidden = 8'hff;
   localparam logic [3:0]  period_reset     = 4'h0;
   localparam logic [3:0]  vector_one_low   = 4'h8;
   localparam logic [3:0]  vector_two_low   = 4'h9;
   localparam logic [31:0] wd_base_us       = 32'h0000_0200;
   // reset pulse length and axi response codes
   localparam int reset_pulse_us            = 1;
   localparam int clock_mhz                 = 100;
   localparam int reset_pulse_cycles        = reset_pulse_us * clock_mhz;
   localparam logic [1:0] resp_okay         = 2'b00;
   localparam logic [1:0] resp_slverr       = 2'b10;
endpackage
